// [rtl/itpmf_pkg.sv]
// Package for the memory-cycle forwarding decoder of the bridge
package itpmf_pkg;

  // Configuration register offset and reset value
  localparam logic [7:0] MCFG_OFFSET = 8'h69;
  localparam logic [7:0] MCFG_RESET  = 8'h02;
  // Writable bits; bit 0 is reserved and always reads zero
  localparam logic [7:0] MCFG_WMASK  = 8'hfe;
  // Bit 2 is also reserved where the A/B segment is not supported
  localparam logic [7:0] MCFG_AB_BIT = 8'h04;

  // Width of the ISA memory address (LA/SA, 16 MB space)
  localparam int ADDR_W = 24;
  // The limit field counts in 1 MB units: compare address bits 23:20
  localparam int MB_LSB = 20;
  localparam int MB_W   = 4;

  // Legacy regions below 1 MB
  localparam logic [ADDR_W-1:0] R512_LO  = 24'h080000;
  localparam logic [ADDR_W-1:0] R512_HI  = 24'h09ffff;
  localparam logic [ADDR_W-1:0] ABSEG_LO = 24'h0a0000;
  localparam logic [ADDR_W-1:0] ABSEG_HI = 24'h0bffff;
  localparam logic [ADDR_W-1:0] LBIOS_LO = 24'h0e0000;
  localparam logic [ADDR_W-1:0] LBIOS_HI = 24'h0effff;
  // Rest of the 640 KB - 1 MB hole, always contained to ISA
  localparam logic [ADDR_W-1:0] HOLE_LO  = 24'h0a0000;
  localparam logic [ADDR_W-1:0] HOLE_HI  = 24'h0fffff;

  // Layout of the top-of-memory configuration register
  typedef struct packed {
    logic [MB_W-1:0] limit;     // Bits 7:4, code n means (n+1) MB
    logic            lbios_fwd; // Bit 3, lower BIOS forwarding
    logic            ab_fwd;    // Bit 2, A/B segment forwarding
    logic            r512_fwd;  // Bit 1, 512-640 KB forwarding
    logic            rsvd;      // Bit 0, reserved
  } itpmf_mcfg_t;

  // Configuration space byte access for this function
  typedef struct packed {
    logic       sel;   // Access addressed to this function
    logic       wr;    // Write strobe
    logic       rd;    // Read strobe
    logic [7:0] addr;  // Byte offset
    logic [7:0] wdata; // Write data
  } itpmf_cfg_t;

  // Memory cycle seen by the decoder
  typedef struct packed {
    logic              start;    // One-cycle pulse, address valid
    logic              done;     // One-cycle pulse at cycle end
    logic              from_pci; // 1: PCI master, 0: ISA master/DMA
    logic [ADDR_W-1:0] addr;     // Memory address
  } itpmf_cyc_t;

  // Cycle tracking states
  typedef enum logic [0:0] {
    CYC_IDLE   = 1'b0,
    CYC_ACTIVE = 1'b1
  } itpmf_state_t;

endpackage

// [rtl/itpmf_cfg_reg.sv]
// Top-of-memory configuration register with its config-space port
`timescale 1ns/100ps
module itpmf_cfg_reg #(
  parameter bit AB_SEG_SUPPORT = 1'b1
) (
  input  wire logic                   clk_i,       // Bridge clock
  input  wire logic                   reset_n_i,   // Async reset, low
  input  wire logic                   ce_i,        // Clock enable
  input  wire itpmf_pkg::itpmf_cfg_t  cfg_i,       // Config access
  output logic                        cfg_hit_o,   // Offset claimed
  output logic [7:0]                  cfg_rdata_o, // Read data
  output itpmf_pkg::itpmf_mcfg_t      mcfg_o       // Register contents
);
  import itpmf_pkg::*;

  logic [7:0] top_of_memory_config_r;
  logic [7:0] top_of_memory_config_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] wmask;

  // Bit 2 becomes reserved on the earlier variant
  assign wmask = AB_SEG_SUPPORT ? MCFG_WMASK : (MCFG_WMASK & ~MCFG_AB_BIT);
  assign cfg_hit_o   = cfg_i.sel && (cfg_i.addr == MCFG_OFFSET);
  assign mcfg_o      = itpmf_mcfg_t'(top_of_memory_config_r);
  assign cfg_rdata_o = rdata_r;

  // Write masks the reserved bits, read returns the stored byte
  always_comb
  begin
    top_of_memory_config_nxt = top_of_memory_config_r;
    rdata_nxt                = rdata_r;
    if (cfg_hit_o && cfg_i.wr)
      top_of_memory_config_nxt = cfg_i.wdata & wmask;
    if (cfg_hit_o && cfg_i.rd)
      rdata_nxt = top_of_memory_config_r;
  end

  // Registers only; reset default is 1 MB with 512-640 KB forwarded
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      top_of_memory_config_r <= MCFG_RESET;
      rdata_r                <= '0;
    end
    else if (ce_i)
    begin
      top_of_memory_config_r <= top_of_memory_config_nxt;
      rdata_r                <= rdata_nxt;
    end
  end

  a_rsvd_reads_zero: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && cfg_hit_o && cfg_i.rd |=> cfg_rdata_o[0] == 1'b0)
    else $error("reserved bit 0 read back as one");

endmodule

// [rtl/itpmf_top.sv]
// Memory-cycle forwarding decoder: ISA/DMA cycles to PCI or ISA
// Summary of operation
// - Limit field bits 7:4, code n = (n+1) MB
// - Forward cycles below limit and outside hole
// - Bit 3 forwards lower BIOS unless chip-select enabled
// - Lower BIOS chip-select enabled keeps BIOS on ISA
// - Bit 2 forwards A/B segment, later variant
// - Bit 1 forwards 512-640 KB region
// - Lower BIOS accesses with chip-select enabled assert chip select and output enable
`timescale 1ns/100ps
module itpmf_top #(
  parameter bit AB_SEG_SUPPORT = 1'b1 // 0 for the earlier variant
) (
  input  wire logic                  clk_i,        // Bridge clock, 40 MHz
  input  wire logic                  reset_n_i,    // Async reset, low
  input  wire logic                  ce_i,         // Clock enable
  input  wire itpmf_pkg::itpmf_cfg_t cfg_i,        // Config access
  input  wire logic                  lbios_cs_en_i, // Lower BIOS CS enable
  input  wire itpmf_pkg::itpmf_cyc_t cyc_i,        // Memory cycle
  output logic                       cfg_hit_o,    // Offset claimed
  output logic [7:0]                 cfg_rdata_o,  // Config read data
  output logic                       dec_valid_o,  // Decision ready pulse
  output logic                       fwd_to_pci_o, // 1: forward to PCI
  output logic                       bios_chip_select_n_o,       // BIOS CS
  output logic                       peripheral_output_enable_n_o // XD OE
);
  import itpmf_pkg::*;

  itpmf_mcfg_t  mcfg;
  itpmf_state_t state_r;
  itpmf_state_t state_nxt;
  logic         fwd_r;
  logic         fwd_nxt;
  logic         valid_r;
  logic         valid_nxt;
  logic         bios_r;
  logic         bios_nxt;
  logic         fwd_now;
  logic         bios_now;

  // Inclusive address range check, used by every region decode
  function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Register block; firmware must program it before masters run
  itpmf_cfg_reg #(
    .AB_SEG_SUPPORT (AB_SEG_SUPPORT)
  ) u_cfg (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .ce_i        (ce_i),
    .cfg_i       (cfg_i),
    .cfg_hit_o   (cfg_hit_o),
    .cfg_rdata_o (cfg_rdata_o),
    .mcfg_o      (mcfg)
  );

  // Forwarding decision for the cycle on the inputs right now.
  // Legacy regions take priority over the limit compare, since they
  // all sit below 1 MB which the smallest limit already covers.
  always_comb
  begin
    fwd_now = 1'b0;
    if (cyc_i.from_pci)
      fwd_now = 1'b0; // PCI cycles are never sent back to PCI
    else if (in_range(cyc_i.addr, R512_LO, R512_HI))
      fwd_now = mcfg.r512_fwd;
    else if (in_range(cyc_i.addr, ABSEG_LO, ABSEG_HI))
      fwd_now = AB_SEG_SUPPORT && mcfg.ab_fwd;
    else if (in_range(cyc_i.addr, LBIOS_LO, LBIOS_HI))
      fwd_now = mcfg.lbios_fwd && !lbios_cs_en_i;
    else if (in_range(cyc_i.addr, HOLE_LO, HOLE_HI))
      fwd_now = 1'b0;
    else
      fwd_now = (cyc_i.addr[MB_LSB +: MB_W] <= mcfg.limit);
  end

  // BIOS chip select for PCI or ISA masters in the lower BIOS block
  assign bios_now = lbios_cs_en_i &&
                    in_range(cyc_i.addr, LBIOS_LO, LBIOS_HI);

  // Cycle tracking: the decision is taken once at start and held,
  // so a register write in mid-cycle cannot flip a running cycle
  always_comb
  begin
    state_nxt = state_r;
    fwd_nxt   = fwd_r;
    valid_nxt = 1'b0;
    bios_nxt  = bios_r;
    unique case (state_r)
      CYC_IDLE:
      begin
        if (cyc_i.start)
        begin
          state_nxt = CYC_ACTIVE;
          fwd_nxt   = fwd_now;
          valid_nxt = 1'b1;
          bios_nxt  = bios_now;
        end
      end
      CYC_ACTIVE:
      begin
        if (cyc_i.start)
        begin
          // Back-to-back cycle: a new start also closes the old one
          fwd_nxt   = fwd_now;
          valid_nxt = 1'b1;
          bios_nxt  = bios_now;
        end
        else if (cyc_i.done)
        begin
          state_nxt = CYC_IDLE;
          bios_nxt  = 1'b0;
        end
      end
    endcase
  end

  // State registers, frozen while the clock enable is low
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_r <= CYC_IDLE;
      fwd_r   <= 1'b0;
      valid_r <= 1'b0;
      bios_r  <= 1'b0;
    end
    else if (ce_i)
    begin
      state_r <= state_nxt;
      fwd_r   <= fwd_nxt;
      valid_r <= valid_nxt;
      bios_r  <= bios_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign dec_valid_o                  = valid_r;
  assign fwd_to_pci_o                 = fwd_r;
  assign bios_chip_select_n_o         = !bios_r;
  assign peripheral_output_enable_n_o = !bios_r;

  // Checks on the decoder
  a_limit_above: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && cyc_i.start && !cyc_i.from_pci &&
    (cyc_i.addr[MB_LSB +: MB_W] > mcfg.limit)
    |=> !fwd_to_pci_o && dec_valid_o)
    else $error("cycle above the limit was forwarded");

  a_limit_below: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && cyc_i.start && !cyc_i.from_pci &&
    (cyc_i.addr[MB_LSB +: MB_W] != 4'h0) &&
    (cyc_i.addr[MB_LSB +: MB_W] <= mcfg.limit)
    |=> fwd_to_pci_o)
    else $error("cycle below the limit was kept on ISA");

  a_hole_kept: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && cyc_i.start && (cyc_i.addr > ABSEG_HI) &&
    (cyc_i.addr <= HOLE_HI) && !in_range(cyc_i.addr, LBIOS_LO, LBIOS_HI)
    |=> !fwd_to_pci_o)
    else $error("hole access was forwarded");

  a_lbios_fwd: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && cyc_i.start && !cyc_i.from_pci &&
    in_range(cyc_i.addr, LBIOS_LO, LBIOS_HI) && !lbios_cs_en_i
    |=> fwd_to_pci_o == $past(mcfg.lbios_fwd))
    else $error("lower BIOS forwarding does not follow bit 3");

  a_lbios_kept: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && cyc_i.start && lbios_cs_en_i &&
    in_range(cyc_i.addr, LBIOS_LO, LBIOS_HI)
    |=> !fwd_to_pci_o)
    else $error("lower BIOS forwarded while chip select enabled");

  a_abseg_fwd: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && cyc_i.start && !cyc_i.from_pci &&
    in_range(cyc_i.addr, ABSEG_LO, ABSEG_HI)
    |=> fwd_to_pci_o == (AB_SEG_SUPPORT && $past(mcfg.ab_fwd)))
    else $error("A/B segment forwarding does not follow bit 2");

  a_r512_fwd: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && cyc_i.start && !cyc_i.from_pci &&
    in_range(cyc_i.addr, R512_LO, R512_HI)
    |=> fwd_to_pci_o == $past(mcfg.r512_fwd))
    else $error("512-640 KB forwarding does not follow bit 1");

  a_bios_select: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && cyc_i.start && lbios_cs_en_i &&
    in_range(cyc_i.addr, LBIOS_LO, LBIOS_HI)
    |=> !bios_chip_select_n_o && !peripheral_output_enable_n_o)
    else $error("BIOS chip select missing for lower BIOS access");

  a_decision_held: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    state_r == CYC_ACTIVE && !cyc_i.start |=> $stable(fwd_to_pci_o))
    else $error("decision changed inside a running cycle");

  c_fwd_cycle: cover property (
    @(posedge clk_i) disable iff (!reset_n_i)
    dec_valid_o && fwd_to_pci_o);
  c_kept_cycle: cover property (
    @(posedge clk_i) disable iff (!reset_n_i)
    dec_valid_o && !fwd_to_pci_o);
  c_bios_select: cover property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !bios_chip_select_n_o ##1 bios_chip_select_n_o);

endmodule

// [verification/itpmf_isa_master.sv]
// Behavioural ISA master / DMA side that runs memory cycles
`timescale 1ns/100ps
module itpmf_isa_master (
  input  wire logic                        clk_i,  // Bridge clock
  input  wire logic                        go_i,   // Run one cycle
  input  wire logic                        pci_i,  // Cycle from PCI
  input  wire logic [itpmf_pkg::ADDR_W-1:0] addr_i, // Cycle address
  input  wire logic [3:0]                  hold_i, // Extra beats
  output itpmf_pkg::itpmf_cyc_t            cyc_o,  // Cycle strobes
  output logic                             busy_o  // Cycle running
);
  import itpmf_pkg::*;
  int         cnt;
  logic       go;
  itpmf_cyc_t nxt;
  // One process drives every output, each once per edge. The address
  // is scrambled after the start beat, so a late sample shows up
  initial
  begin
    cyc_o  = '0;
    busy_o = 1'b0;
    cnt    = 0;
    forever
    begin
      @(posedge clk_i);
      go = go_i;
      #2;
      nxt       = cyc_o;
      nxt.start = 1'b0;
      nxt.done  = 1'b0;
      nxt.addr  = ~cyc_o.addr;
      if (busy_o)
      begin
        cnt--;
        if (cnt == 0)
        begin
          nxt.done = 1'b1;
          busy_o   = 1'b0;
        end
      end
      else if (go)
      begin
        nxt    = {1'b1, 1'b0, pci_i, addr_i};
        busy_o = 1'b1;
        cnt    = hold_i + 1;
      end
      cyc_o = nxt;
    end
  end
endmodule

// [verification/test_itpmf_top.sv]
// Self-checking bench for the memory-cycle forwarding decoder
`timescale 1ns/100ps
module test_itpmf_top;
  import itpmf_pkg::*;
  logic              clk_i, reset_n_i, ce_i, lbios, go, m_pci, busy;
  logic [ADDR_W-1:0] m_addr;
  logic [3:0]        m_hold;
  itpmf_cfg_t        cfg;
  itpmf_cyc_t        cyc;
  logic              hit, dv, fwd, cs_n, oe_n, fwd_e;
  logic [7:0]        rdata, mcfg, rdata_e;
  int                mismatches, comparisons, seed;

  itpmf_top uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .cfg_i(cfg), .lbios_cs_en_i(lbios), .cyc_i(cyc), .cfg_hit_o(hit),
    .cfg_rdata_o(rdata), .dec_valid_o(dv), .fwd_to_pci_o(fwd),
    .bios_chip_select_n_o(cs_n), .peripheral_output_enable_n_o(oe_n));
  itpmf_isa_master far (.clk_i(clk_i), .go_i(go), .pci_i(m_pci),
    .addr_i(m_addr), .hold_i(m_hold), .cyc_o(cyc), .busy_o(busy));
  // Earlier variant with bit 2 reserved; decision and read data checked
  itpmf_top #(.AB_SEG_SUPPORT(1'b0)) uut_early (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .ce_i(ce_i), .cfg_i(cfg), .lbios_cs_en_i(lbios),
    .cyc_i(cyc), .cfg_hit_o(), .cfg_rdata_o(rdata_e), .dec_valid_o(),
    .fwd_to_pci_o(fwd_e), .bios_chip_select_n_o(),
    .peripheral_output_enable_n_o());

  // 40 MHz bridge clock
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      mismatches++;
    end
  endtask

  task automatic end_of_test;
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Expected decision; PCI cycles are never sent back to PCI
  function automatic logic exp_fwd(input logic [7:0] t,
    input logic [23:0] a, input logic p, input logic c);
    if (p) return 1'b0;
    if (a inside {[24'h080000:24'h09ffff]}) return t[1];
    if (a inside {[24'h0a0000:24'h0bffff]}) return t[2];
    if (a inside {[24'h0e0000:24'h0effff]}) return t[3] && !c;
    if (a inside {[24'h0a0000:24'h0fffff]}) return 1'b0;
    return a[23:20] <= t[7:4];
  endfunction

  // One config byte access; a read answers after the taking edge
  task automatic cfg_acc(input logic w, input logic [7:0] a,
    input logic [7:0] d);
    @(posedge clk_i);
    #2;
    cfg = {1'b1, w, !w, a, d};
    #1;
    check(hit, a == MCFG_OFFSET);
    @(posedge clk_i);
    #2;
    cfg = '0;
    if (w && a == MCFG_OFFSET && ce_i) mcfg = d & MCFG_WMASK;
    if (!w && a == MCFG_OFFSET)
      check(rdata_e, mcfg & ~MCFG_AB_BIT);
  endtask

  // One memory cycle; the register is rewritten two clocks after the decision
  task automatic run_cyc(input logic [23:0] a, input logic p,
    input logic c, input logic [7:0] d);
    logic ef;
    logic en;
    logic ee;
    int   n;
    ef = exp_fwd(mcfg, a, p, c);
    ee = exp_fwd(mcfg & ~MCFG_AB_BIT, a, p, c);
    en = !(c && a inside {[24'h0e0000:24'h0effff]});
    @(posedge clk_i);
    #2;
    {go, m_addr, m_pci, lbios} = {1'b1, a, p, c};
    m_hold = 4'($random(seed));
    @(posedge clk_i);
    #2;
    go = 1'b0;
    @(posedge clk_i);
    #1;
    check(dv, 1'b1);
    check(fwd, ef);
    check(cs_n, en);
    check(oe_n, en);
    check(fwd_e, ee);
    cfg_acc(1'b1, MCFG_OFFSET, d);
    check(fwd, ef);
    check(dv, 1'b0);
    n = 0;
    while (busy === 1'b1 && n < 40)
    begin
      @(posedge clk_i);
      #3;
      n++;
    end
    check(busy, 1'b0);
    @(posedge clk_i);
    #1;
    check(cs_n, 1'b1);
  endtask

  initial
  begin
    logic [23:0] cor [4];
    logic [7:0]  rv [2];
    logic [31:0] r;
    logic [23:0] a;
    cor = '{24'h090000, 24'h0b1234, 24'h0e8000, 24'h0d0000};
    rv = '{8'h0e, 8'h00};
    seed = 32'he56a;
    mismatches = 0;
    comparisons = 0;
    {reset_n_i, ce_i, go, m_pci, lbios} = 5'b01000;
    {cfg, m_addr, m_hold} = '0;
    mcfg = MCFG_RESET;
    repeat (6) @(posedge clk_i);
    #1;
    check({4'h0, dv, fwd, cs_n, oe_n}, 8'h03);
    #1 reset_n_i = 1'b1;
    cfg_acc(1'b0, MCFG_OFFSET, 8'h00);
    check(rdata, MCFG_RESET);
    cfg_acc(1'b1, MCFG_OFFSET, 8'hff);
    cfg_acc(1'b0, MCFG_OFFSET, 8'h00);
    check(rdata, 8'hfe);
    cfg_acc(1'b1, 8'h68, 8'h11);
    cfg_acc(1'b0, 8'h68, 8'h00);
    check(rdata, 8'hfe);
    ce_i = 1'b0;
    cfg_acc(1'b1, MCFG_OFFSET, 8'h00);
    ce_i = 1'b1;
    cfg_acc(1'b0, MCFG_OFFSET, 8'h00);
    check(rdata, mcfg);
    // Firmware sets 15 MB for a hole at 15-16 MB before use
    cfg_acc(1'b1, MCFG_OFFSET, 8'he0);
    run_cyc(24'hf00000, 1'b0, 1'b0, 8'he0);
    run_cyc(24'hefffff, 1'b0, 1'b0, 8'h00);
    run_cyc(24'h100000, 1'b0, 1'b0, 8'hf0);
    run_cyc(24'hffffff, 1'b0, 1'b0, 8'hf0);
    // Every region enable, both chip-select settings, both masters
    foreach (rv[v])
    begin
      cfg_acc(1'b1, MCFG_OFFSET, rv[v]);
      for (int k = 0; k < 16; k++)
        run_cyc(cor[k%4], k[2], k[3], rv[v]);
    end
    repeat (200)
    begin
      r = $random(seed);
      a = r[23:0];
      case (r[30:28])
        3'd0: a = {7'h04, r[16:0]};
        3'd1: a = {7'h05, r[16:0]};
        3'd2: a = {8'h0e, r[15:0]};
        3'd3: a = {4'h0, r[19:0]};
        default: a = r[23:0];
      endcase
      run_cyc(a, r[31], r[27], 8'($random(seed)));
    end
    // Reset in mid-run must clear the outputs and restore the default
    @(posedge clk_i);
    #2 reset_n_i = 1'b0;
    #1 check({4'h0, dv, fwd, cs_n, oe_n}, 8'h03);
    @(posedge clk_i);
    #2 reset_n_i = 1'b1;
    mcfg = MCFG_RESET;
    cfg_acc(1'b0, MCFG_OFFSET, 8'h00);
    check(rdata, MCFG_RESET);
    end_of_test();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #(25 * 40000);
    mismatches++;
    end_of_test();
  end
endmodule
